/* File: verilog/oplc_top.sv */
// module: axi4-lite register bank for the otg port line pull control
//
// Contract
// - d- pull-down is on when control bit 2 is one, off otherwise.
// - d+ pull-down is on when control bit 1 is one, off otherwise.
// - setting bit 0 attaches the 1.5 kilohm d+ pull-up and starts pulsing.
// - clearing bit 0 detaches the d+ pull-up and stops pulsing.
// - in peripheral role d+ pulls high only with bit 0 and vbus sense.
// - internal vbus sense follows presence of 5 v on the vbus pin.
// - ones in the low half at 0374h set control bits; ones in its high half and in the low half at 0376h clear them.
// - status reads show live levels of interrupt sources, not latched copies.
`timescale 1ns/1ns
module oplc_top #(
  parameter int STATUS_W = 16                           // width of the live status word
) (
  input  wire logic                   mclk,             // 250 mhz clock
  input  wire logic                   resetn,           // async reset, active low
  input  wire logic [11:0]            s_axi_awaddr,     // write address
  input  wire logic                   s_axi_awvalid,    // write address valid
  output logic                        s_axi_awready,    // write address ready
  input  wire logic [31:0]            s_axi_wdata,      // write data
  input  wire logic [3:0]             s_axi_wstrb,      // write byte strobes
  input  wire logic                   s_axi_wvalid,     // write data valid
  output logic                        s_axi_wready,     // write data ready
  output logic [1:0]                  s_axi_bresp,      // write response
  output logic                        s_axi_bvalid,     // write response valid
  input  wire logic                   s_axi_bready,     // write response ready
  input  wire logic [11:0]            s_axi_araddr,     // read address
  input  wire logic                   s_axi_arvalid,    // read address valid
  output logic                        s_axi_arready,    // read address ready
  output logic [31:0]                 s_axi_rdata,      // read data
  output logic [1:0]                  s_axi_rresp,      // read response
  output logic                        s_axi_rvalid,     // read data valid
  input  wire logic                   s_axi_rready,     // read data ready
  input  wire logic                   vbus_present,     // 5 v present on vbus pin
  input  wire logic                   port_peripheral_mode, // port 1 fixed as peripheral
  input  wire logic                   bdis_acon_event,  // remote disconnect event pulse
  input  wire logic [STATUS_W-1:0]    otg_irq_levels,   // live interrupt source levels
  output oplc_pkg::oplc_line_t        line,             // line termination controls
  output logic                        vbus_sense        // internal vbus sense
);
  logic [1:0]               rst_sync_q;
  logic                     rst_n;
  logic [15:0]              ctrl_q, ctrl_d;
  oplc_pkg::oplc_ch_state_t wst_q, wst_d, rst_q, rst_d;
  logic                     aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [11:0]              awaddr_q, awaddr_d;
  logic [31:0]              wdata_q, wdata_d;
  logic [3:0]               wstrb_q, wstrb_d;
  logic                     awready_q, awready_d, wready_q, wready_d;
  logic                     bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     wr_do;
  oplc_pkg::oplc_sel_t      wr_sel, rd_sel;
  logic [15:0]              set_bits, clr_bits;

  // address decode shared by the write and read paths
  function automatic oplc_pkg::oplc_sel_t decode(input logic [11:0] addr);
    unique case (addr)
      oplc_pkg::CTRL_SET_ADDR: decode = oplc_pkg::SEL_SET;
      oplc_pkg::CTRL_CLR_ADDR: decode = oplc_pkg::SEL_CLR;
      oplc_pkg::STATUS_ADDR:   decode = oplc_pkg::SEL_STATUS;
      default:                 decode = oplc_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // expand two byte strobes into a 16-bit lane mask
  function automatic logic [15:0] lanes(input logic [1:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lanes

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign wr_sel = decode(awaddr_q);
  assign rd_sel = decode(s_axi_araddr);
  assign wr_do  = aw_have_q & w_have_q & (wst_q == oplc_pkg::ST_IDLE);

  // write channel: latch address and data in either order, then answer
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    wst_d     = wst_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    unique case (wst_q)
      oplc_pkg::ST_IDLE: begin
        if (wr_do) begin
          aw_have_d = 1'b0;
          w_have_d  = 1'b0;
          wst_d     = oplc_pkg::ST_RESP;
          bvalid_d  = 1'b1;
          bresp_d   = (wr_sel == oplc_pkg::SEL_SET || wr_sel == oplc_pkg::SEL_CLR) ?
                      oplc_pkg::RESP_OKAY : oplc_pkg::RESP_SLVERR;
        end
      end
      oplc_pkg::ST_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wst_d    = oplc_pkg::ST_IDLE;
        end
      end
      default: begin
        wst_d    = oplc_pkg::ST_IDLE;
        bvalid_d = 1'b0;
      end
    endcase
    awready_d = (wst_d == oplc_pkg::ST_IDLE) & ~aw_have_d;
    wready_d  = (wst_d == oplc_pkg::ST_IDLE) & ~w_have_d;
  end

  // control register: set and clear addresses, hardware set of the role bit
  always_comb begin
    set_bits = 16'h0000;
    clr_bits = 16'h0000;
    if (wr_do && wr_sel == oplc_pkg::SEL_SET) begin
      set_bits = wdata_q[15:0] & lanes(wstrb_q[1:0]);
      clr_bits = wdata_q[31:16] & lanes(wstrb_q[3:2]);
    end else if (wr_do && wr_sel == oplc_pkg::SEL_CLR) begin
      clr_bits = wdata_q[15:0] & lanes(wstrb_q[1:0]);
    end
    // set is applied after clear so a set wins
    ctrl_d = (ctrl_q & ~clr_bits) | set_bits;
    if (bdis_acon_event && ctrl_q[oplc_pkg::BDIS_ACON_BIT]) begin
      ctrl_d[oplc_pkg::SEL_PERIPH_BIT] = 1'b1;
    end
  end

  // read channel: one read in flight, data captured at address accept
  always_comb begin
    rst_d   = rst_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    unique case (rst_q)
      oplc_pkg::ST_IDLE: begin
        if (s_axi_arvalid && arready_q) begin
          rst_d    = oplc_pkg::ST_RESP;
          rvalid_d = 1'b1;
          rresp_d  = oplc_pkg::RESP_OKAY;
          unique case (rd_sel)
            oplc_pkg::SEL_SET,
            oplc_pkg::SEL_CLR:    rdata_d = {16'h0000, ctrl_q};
            oplc_pkg::SEL_STATUS: rdata_d = 32'(otg_irq_levels);
            default: begin
              rdata_d = 32'h0000_0000;
              rresp_d = oplc_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      oplc_pkg::ST_RESP: begin
        if (s_axi_rready) begin
          rvalid_d = 1'b0;
          rst_d    = oplc_pkg::ST_IDLE;
        end
      end
      default: begin
        rst_d    = oplc_pkg::ST_IDLE;
        rvalid_d = 1'b0;
      end
    endcase
    arready_d = (rst_d == oplc_pkg::ST_IDLE);
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= oplc_pkg::CTRL_RESET;
      wst_q     <= oplc_pkg::ST_IDLE;
      rst_q     <= oplc_pkg::ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      ctrl_q    <= ctrl_d;
      wst_q     <= wst_d;
      rst_q     <= rst_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // line termination stage
  oplc_line_drive u_line (
    .clk                  (mclk),
    .rst_n                (rst_n),
    .ctrl                 (ctrl_q),
    .vbus_present         (vbus_present),
    .port_peripheral_mode (port_peripheral_mode),
    .line                 (line),
    .vbus_sense           (vbus_sense)
  );

  sequence s_set_bit0;
    wr_do && wr_sel == oplc_pkg::SEL_SET && wdata_q[0] && wstrb_q[0];
  endsequence

  property p_set;
    @(posedge mclk) disable iff (!rst_n)
    s_set_bit0 |=> ctrl_q[0] ##1 line.line_pulsing;
  endproperty
  a_set: assert property (p_set) else $error("set address did not set bit");

  property p_clr;
    @(posedge mclk) disable iff (!rst_n)
    wr_do && wr_sel == oplc_pkg::SEL_CLR && wdata_q[1] && wstrb_q[0] |=> !ctrl_q[1];
  endproperty
  a_clr: assert property (p_clr) else $error("clear address did not clear bit");

  property p_hi_clr;
    @(posedge mclk) disable iff (!rst_n)
    wr_do && wr_sel == oplc_pkg::SEL_SET && wdata_q[17] && wstrb_q[2] && !wdata_q[1]
      |=> !ctrl_q[1];
  endproperty
  a_hi_clr: assert property (p_hi_clr) else $error("high half did not clear");

  property p_status;
    @(posedge mclk) disable iff (!rst_n)
    s_axi_arvalid && arready_q && rd_sel == oplc_pkg::SEL_STATUS
      |=> s_axi_rvalid && s_axi_rdata == 32'($past(otg_irq_levels));
  endproperty
  a_status: assert property (p_status) else $error("status not live");
endmodule : oplc_top

/* File: pkg/oplc_pkg.sv */
// package: register map, bit positions and types for the port line pull control
package oplc_pkg;
  localparam int          ADDR_W          = 12;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] CTRL_SET_IDX    = 12'h374;
  localparam logic [11:0] CTRL_CLR_IDX    = 12'h376;
  localparam logic [11:0] STATUS_IDX      = 12'h380;
  localparam logic [11:0] CTRL_SET_ADDR   = {CTRL_SET_IDX[9:0], 2'b00};
  localparam logic [11:0] CTRL_CLR_ADDR   = {CTRL_CLR_IDX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR     = {STATUS_IDX[9:0], 2'b00};
  // control bit positions
  localparam int          DPLUS_PU_BIT    = 0;
  localparam int          DPLUS_PD_BIT    = 1;
  localparam int          DMINUS_PD_BIT   = 2;
  localparam int          SEL_PERIPH_BIT  = 7;
  localparam int          BDIS_ACON_BIT   = 8;
  localparam int          OTG_DISABLE_BIT = 10;
  localparam logic [15:0] CTRL_RESET      = 16'h0086;
  // software start-up values for host and peripheral use
  localparam logic [31:0] HOST_INIT       = 32'h0080_0018;
  localparam logic [31:0] PERIPH_INIT     = 32'h0006_0400;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'h0,
    SEL_SET    = 2'h1,
    SEL_CLR    = 2'h2,
    SEL_STATUS = 2'h3
  } oplc_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } oplc_ch_state_t;

  typedef struct packed {
    logic dminus_pull_down_enable;
    logic dplus_pull_down_enable;
    logic dplus_pull_up_connect;
    logic line_pulsing;
  } oplc_line_t;
endpackage : oplc_pkg

/* File: verilog/oplc_line_drive.sv */
// module: line termination drive and vbus sense for port 1
`timescale 1ns/1ns
module oplc_line_drive (
  input  wire logic               clk,                  // system clock
  input  wire logic               rst_n,                // synchronised reset, active low
  input  wire logic [15:0]        ctrl,                 // control register contents
  input  wire logic               vbus_present,         // 5 v comparator on the vbus pin
  input  wire logic               port_peripheral_mode, // port 1 fixed as peripheral
  output oplc_pkg::oplc_line_t    line,                 // registered line controls
  output logic                    vbus_sense            // registered internal vbus signal
);
  oplc_pkg::oplc_line_t line_q, line_d;
  logic                 vbus_q, vbus_d;
  logic                 periph_role;

  // next line state from control bits, role and vbus
  always_comb begin
    vbus_d      = vbus_present;
    periph_role = port_peripheral_mode |
                  (~ctrl[oplc_pkg::OTG_DISABLE_BIT] & ctrl[oplc_pkg::SEL_PERIPH_BIT]);
    line_d.dminus_pull_down_enable = ctrl[oplc_pkg::DMINUS_PD_BIT];
    line_d.dplus_pull_down_enable  = ctrl[oplc_pkg::DPLUS_PD_BIT];
    line_d.line_pulsing            = ctrl[oplc_pkg::DPLUS_PU_BIT];
    // peripheral role gates the pull-up with vbus sense
    line_d.dplus_pull_up_connect   = ctrl[oplc_pkg::DPLUS_PU_BIT] &
                                     (~periph_role | vbus_q);
  end

  // output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= '0;
      vbus_q <= 1'b0;
    end else begin
      line_q <= line_d;
      vbus_q <= vbus_d;
    end
  end

  assign line       = line_q;
  assign vbus_sense = vbus_q;

  sequence s_pu_on;
    $rose(ctrl[oplc_pkg::DPLUS_PU_BIT]) ##0 !periph_role;
  endsequence

  // the first edge after reset still shows the cleared line flops, so it is skipped
  property p_dm_pd;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> line.dminus_pull_down_enable == $past(ctrl[oplc_pkg::DMINUS_PD_BIT]);
  endproperty
  a_dm_pd: assert property (p_dm_pd) else $error("d- pull-down mismatch");

  property p_dp_pd;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> line.dplus_pull_down_enable == $past(ctrl[oplc_pkg::DPLUS_PD_BIT]);
  endproperty
  a_dp_pd: assert property (p_dp_pd) else $error("d+ pull-down mismatch");

  property p_pu_on;
    @(posedge clk) disable iff (!rst_n)
    s_pu_on |=> line.dplus_pull_up_connect && line.line_pulsing;
  endproperty
  a_pu_on: assert property (p_pu_on) else $error("pull-up did not attach");

  property p_pu_off;
    @(posedge clk) disable iff (!rst_n)
    !ctrl[oplc_pkg::DPLUS_PU_BIT] |=> !line.dplus_pull_up_connect && !line.line_pulsing;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up did not detach");

  property p_vbus_gate;
    @(posedge clk) disable iff (!rst_n)
    periph_role && !vbus_sense |=> !line.dplus_pull_up_connect;
  endproperty
  a_vbus_gate: assert property (p_vbus_gate) else $error("pull-up without vbus");

  property p_vbus;
    @(posedge clk) disable iff (!rst_n)
    ##1 vbus_sense == $past(vbus_present);
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus sense does not follow pin");
endmodule : oplc_line_drive

/* File: sim/oplc_usb_peer.sv */
// partner model: usb peer on port 1 with vbus supply and line pull-downs
`timescale 1ns/1ns
module oplc_usb_peer (
  input  wire logic           vbus_on,      // peer supplies 5 v on vbus
  input  oplc_pkg::oplc_line_t line,        // termination controls from the block
  output logic                vbus_present, // level seen at the vbus pin
  output logic                dplus_level,  // resolved d+ wire level
  output logic                dminus_level  // resolved d- wire level
);
  // the peer's weak pull-downs hold both lines low unless the 1.5k pull-up is attached
  assign vbus_present = vbus_on;
  assign dplus_level  = line.dplus_pull_up_connect;
  assign dminus_level = 1'b0;
endmodule : oplc_usb_peer

/* File: sim/testbench.sv */
// testbench: register writes, line termination, vbus gating and status reads
`timescale 1ns/1ns
module testbench;
  logic mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pmode, vbus_on, vbus_present, vbus_sense, bdis;
  logic dp_lvl, dm_lvl;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] irq, ctl;
  oplc_pkg::oplc_line_t line;
  int mismatches, checks;

  oplc_top u_dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .vbus_present(vbus_present), .port_peripheral_mode(pmode),
    .bdis_acon_event(bdis), .otg_irq_levels(irq), .line(line), .vbus_sense(vbus_sense));
  oplc_usb_peer u_peer (.vbus_on(vbus_on), .line(line), .vbus_present(vbus_present),
    .dplus_level(dp_lvl), .dminus_level(dm_lvl));

  // 250 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp; bready <= 1'b0; break;
      end
    end
    if (n == 60) begin
      mismatches++; give_verdict();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata; rs = rresp; rready <= 1'b0; break;
      end
    end
    if (n == 60) begin
      mismatches++; give_verdict();
    end
  endtask : axi_rd

  // expected line controls: peripheral role gates the pull-up with vbus
  function automatic logic [3:0] exp_line(input logic [15:0] c);
    logic per;
    per = pmode | (!c[oplc_pkg::OTG_DISABLE_BIT] & c[oplc_pkg::SEL_PERIPH_BIT]);
    return {c[2], c[1], c[0] & (!per | vbus_on), c[0]};
  endfunction : exp_line

  task automatic chk_line();
    logic [3:0] e;
    repeat (3) @(posedge mclk);
    e = exp_line(ctl);
    check({28'h0, line}, {28'h0, e}, "line");
    check({31'h0, dp_lvl}, {31'h0, e[1]}, "dplus wire");
    check({31'h0, dm_lvl}, 32'h0, "dminus wire");
    axi_rd(oplc_pkg::CTRL_SET_ADDR, d, r);
    check(d, {16'h0, ctl}, "control readback");
    check({30'h0, r}, {30'h0, oplc_pkg::RESP_OKAY}, "readback rresp");
  endtask : chk_line

  // write at the set address: low half sets, high half clears
  task automatic setw(input logic [31:0] v);
    axi_wr(oplc_pkg::CTRL_SET_ADDR, v, r);
    check({30'h0, r}, {30'h0, oplc_pkg::RESP_OKAY}, "set bresp");
    ctl = (ctl & ~v[31:16]) | v[15:0];
    chk_line();
  endtask : setw

  task automatic clrw(input logic [31:0] v);
    axi_wr(oplc_pkg::CTRL_CLR_ADDR, v, r);
    check({30'h0, r}, {30'h0, oplc_pkg::RESP_OKAY}, "clear bresp");
    ctl = ctl & ~v[15:0];
    chk_line();
  endtask : clrw

  task automatic sc_bits();
    for (int k = 0; k < 3; k++) begin
      setw(32'h1 << k);
      clrw(32'h1 << k);
    end
    setw(32'h0004_0003);
    setw(32'h0003_0004);
  endtask : sc_bits

  task automatic sc_bdis();
    clrw(32'h80);
    setw(32'h100);
    @(posedge mclk) bdis <= 1'b1;
    @(posedge mclk) bdis <= 1'b0;
    ctl = ctl | 16'h80;
    chk_line();
    clrw(32'h181);
  endtask : sc_bdis

  task automatic sc_vbus();
    pmode <= 1'b1;
    vbus_on <= 1'b0;
    setw(32'h1);
    vbus_on <= 1'b1;
    chk_line();
    check({31'h0, vbus_sense}, 32'h1, "vbus sense on");
    vbus_on <= 1'b0;
    chk_line();
    check({31'h0, vbus_sense}, 32'h0, "vbus sense off");
    pmode <= 1'b0;
  endtask : sc_vbus

  task automatic sc_status();
    @(posedge mclk) irq <= 16'h5a3c;
    axi_rd(oplc_pkg::STATUS_ADDR, d, r);
    check(d, 32'h0000_5a3c, "status live");
    @(posedge mclk) irq <= 16'h0001;
    axi_rd(oplc_pkg::STATUS_ADDR, d, r);
    check(d, 32'h0000_0001, "status follows");
  endtask : sc_status

  task automatic sc_unmapped();
    axi_wr(12'h100, 32'hffff_ffff, r);
    check({30'h0, r}, {30'h0, oplc_pkg::RESP_SLVERR}, "unmapped bresp");
    axi_rd(12'h100, d, r);
    check({d[29:0], r}, {30'h0, oplc_pkg::RESP_SLVERR}, "unmapped read");
    axi_wr(oplc_pkg::STATUS_ADDR, 32'hffff_ffff, r);
    check({30'h0, r}, {30'h0, oplc_pkg::RESP_SLVERR}, "status write bresp");
    axi_rd(oplc_pkg::CTRL_CLR_ADDR, d, r);
    check(d, {16'h0, ctl}, "clear address read");
  endtask : sc_unmapped

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, pmode, vbus_on, bdis} = '0;
    {awaddr, araddr, wdata, wstrb, irq} = '0;
    mismatches = 0;
    checks = 0;
    ctl = oplc_pkg::CTRL_RESET;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    // the line flops load the control value only after the internal reset lifts
    repeat (2) @(posedge mclk);
    chk_line();
    setw(oplc_pkg::HOST_INIT);
    sc_bits();
    sc_bdis();
    setw(oplc_pkg::PERIPH_INIT);
    sc_vbus();
    sc_status();
    sc_unmapped();
    give_verdict();
  end
endmodule : testbench
